// ===== cct_core.sv
/*
 * Control core of a 16-bit capture/compare timer with AXI4-Lite registers.
 * Assumes wait, freeze and test mode levels come from the same clock and
 * channel pins come from outside, so they are synchronised here.
 */
// What this block does
// - Mode bit chooses capture or compare
// - Missing channel bits ignore writes, read zero
// - Force register always reads zero
// - Force runs compare pin action, no flag
// - Force beats same-cycle match, flag stays clear
// - Sixteen-bit up counter on prescaled ticks
// - Counter writable only in test mode
// - First period after counter write may differ
// - Enable clear stops whole timer
// - No pulse accumulator tick while inactive
// - Stop-in-wait halts timer and accumulator
// - Stop-in-freeze halts counter only
// - Fast clear by channel value access
// - Fast clear overflow flag by counter access
// - Precision bit chooses legacy or precise divider
// - Precision bit accepts one write only
// - Overflow toggles pin of compare channels
// - Overflow toggle beats forced compare
// - Legacy code divides by one to 128
// - New factor waits for zero stages
// - Action code: none, toggle, low, high
// - Write one clears flag while enabled
`timescale 1ns/1ns
module cct_core
	import cct_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic waitMode,
	input wire logic freezeMode,
	input wire logic testMode,
	input wire logic [NUM_CH-1:0] chPinIn,
	output logic [NUM_CH-1:0] chPinOut,
	output logic [NUM_CH-1:0] chPinOe,
	output logic paTick
);

	// Word index of a byte address.
	function automatic logic [5:0] regIndex(input logic [ADDR_W-1:0] a);
		return a[7:2];
	endfunction : regIndex

	// True for the even index that holds a channel value.
	function automatic logic isChVal(input logic [5:0] idx);
		return (idx >= IDX_CHVAL) && (idx < 6'(IDX_CHVAL + 2 * NUM_CH))
			&& !idx[0];
	endfunction : isChVal

	// Channel number addressed by a channel value index.
	function automatic logic [1:0] chOf(input logic [5:0] idx);
		return 2'(6'(idx - IDX_CHVAL) >> 1);
	endfunction : chOf

	logic rstMeta_n;
	logic rstSync_n;
	logic [NUM_CH-1:0] pinMeta_q;
	logic [NUM_CH-1:0] pinSync_q;
	logic [NUM_CH-1:0] pinPrev_q;
	logic [NUM_CH-1:0] mode_q;
	logic [NUM_CH-1:0] toggle_q;
	logic [2*NUM_CH-1:0] action_q;
	logic [2*NUM_CH-1:0] edge_q;
	logic [LEG_W-1:0] legacy_q;
	logic [PRE_W-1:0] precise_q;
	cct_ctrl_type ctrl_q;
	logic precDone_q;
	logic [NUM_CH-1:0] chFlag_q;
	logic ovFlag_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] chVal_q [NUM_CH];
	logic [NUM_CH-1:0] pinOut_q;
	logic bValid_q;
	logic [1:0] bResp_q;
	logic rValid_q;
	logic [1:0] rResp_q;
	logic [31:0] rData_q;
	logic [31:0] rdData;
	logic wrFire;
	logic rdFire;
	logic [5:0] wrIdx;
	logic [5:0] rdIdx;
	logic wrLo;
	logic wrHi;
	logic [7:0] wb;
	logic active;
	logic cntRun;
	logic preTick;
	logic cntTick;
	logic cntWrite;
	logic [CNT_W-1:0] cntNext;
	logic wrap;
	logic [NUM_CH-1:0] forceHit;
	logic [NUM_CH-1:0] match;
	logic [NUM_CH-1:0] capture;
	logic [NUM_CH-1:0] chClr;
	logic cntAccess;

	// Reset is released through two flip-flops.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	// Channel pins pass two flip-flops; the third stage finds edges.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
			pinPrev_q <= '0;
		end else begin
			pinMeta_q <= chPinIn;
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
		end
	end

	// Write channel takes address and data together, one at a time.
	assign wrFire = s_axi_awvalid && s_axi_wvalid && !bValid_q;
	assign s_axi_awready = wrFire;
	assign s_axi_wready = wrFire;
	assign wrIdx = regIndex(s_axi_awaddr);
	assign wrLo = wrFire && s_axi_wstrb[0];
	assign wrHi = wrFire && s_axi_wstrb[1];
	assign wb = s_axi_wdata[7:0];
	assign rdFire = s_axi_arvalid && !rValid_q;
	assign s_axi_arready = !rValid_q;
	assign rdIdx = regIndex(s_axi_araddr);

	// Plain read/write configuration registers; the per-channel ones sized to the channels.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			mode_q <= '0;
			toggle_q <= '0;
			action_q <= '0;
			edge_q <= '0;
			legacy_q <= '0;
			precise_q <= '0;
		end else if (wrLo) begin
			case (wrIdx)
				IDX_MODE: mode_q <= wb[NUM_CH-1:0];
				IDX_TOGGLE: toggle_q <= wb[NUM_CH-1:0];
				IDX_ACTION: action_q <= wb[2*NUM_CH-1:0];
				IDX_EDGE: edge_q <= wb[2*NUM_CH-1:0];
				IDX_CTRL2: legacy_q <= wb[LEG_W-1:0];
				IDX_PRECISE: precise_q <= wb;
				default: ;
			endcase
		end
	end

	// Global control; the precision bit is taken from the first write only.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ctrl_q <= '0;
			precDone_q <= 1'b0;
		end else if (wrLo && wrIdx == IDX_CTRL1) begin
			ctrl_q.en <= wb[BIT_EN];
			ctrl_q.stopWait <= wb[BIT_STOPWAIT];
			ctrl_q.stopFreeze <= wb[BIT_STOPFRZ];
			ctrl_q.fastClr <= wb[BIT_FASTCLR];
			precDone_q <= 1'b1;
			if (!precDone_q) begin
				ctrl_q.precSel <= wb[BIT_PRECSEL];
			end
		end
	end

	// Run conditions: wait stops everything, freeze only the counter.
	assign active = ctrl_q.en && !(waitMode && ctrl_q.stopWait);
	assign cntRun = active && !(freezeMode && ctrl_q.stopFreeze);
	assign cntTick = preTick && cntRun;
	assign cntNext = CNT_W'(cnt_q + 1'b1);
	assign wrap = cntTick && !cntWrite && (cnt_q == CNT_MAX);
	assign cntWrite = testMode && (wrLo || wrHi)
		&& (wrIdx == IDX_CNT_HI || wrIdx == IDX_CNT_LO);

	cct_prescaler #(
		.PRE_WIDTH(PRE_W)
	) u_prescaler (
		.ref_clk(ref_clk),
		.rstSync_n(rstSync_n),
		.run(active),
		.precSel(ctrl_q.precSel),
		.legacyCode(legacy_q),
		.preciseDiv(precise_q),
		.tick(preTick),
		.paTick(paTick)
	);

	// Counter counts on ticks; test mode writes bypass the prescaler phase.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			cnt_q <= '0;
		end else if (cntWrite) begin
			if (wrIdx == IDX_CNT_HI) begin
				cnt_q[15:8] <= wb;
			end else begin
				cnt_q[7:0] <= wb;
			end
		end else if (cntTick) begin
			cnt_q <= cntNext;
		end
	end

	// Channel events and pin actions, one copy per channel.
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic rise;
			logic fall;
			logic [1:0] act;
			assign rise = pinSync_q[ch] && !pinPrev_q[ch];
			assign fall = !pinSync_q[ch] && pinPrev_q[ch];
			assign act = action_q[2*ch+:2];
			assign forceHit[ch] = wrLo && wrIdx == IDX_FORCE
				&& wb[ch] && mode_q[ch];
			assign match[ch] = cntTick && mode_q[ch]
				&& cntNext == chVal_q[ch];
			assign capture[ch] = !mode_q[ch] && active
				&& ((edge_q[2*ch] && rise)
				|| (edge_q[2*ch+1] && fall));
			assign chClr[ch] = (wrLo && wrIdx == IDX_CHFLAG
				&& ctrl_q.en && wb[ch])
				|| (ctrl_q.fastClr && rdFire && isChVal(rdIdx)
				&& chOf(rdIdx) == ch && !mode_q[ch])
				|| (ctrl_q.fastClr && wrFire && isChVal(wrIdx)
				&& chOf(wrIdx) == ch && mode_q[ch]);
			assign chPinOe[ch] = mode_q[ch]
				&& (act != ACT_NONE || toggle_q[ch]);

			// Capture stores the counter; software may load a compare value.
			always_ff @(posedge ref_clk or negedge rstSync_n) begin
				if (!rstSync_n) begin
					chVal_q[ch] <= '0;
				end else if (capture[ch]) begin
					chVal_q[ch] <= cnt_q;
				end else if (isChVal(wrIdx) && chOf(wrIdx) == ch) begin
					if (wrLo) begin
						chVal_q[ch][7:0] <= wb;
					end
					if (wrHi) begin
						chVal_q[ch][15:8] <= s_axi_wdata[15:8];
					end
				end
			end

			// Flag set beats clear; a forced compare sets nothing.
			always_ff @(posedge ref_clk or negedge rstSync_n) begin
				if (!rstSync_n) begin
					chFlag_q[ch] <= 1'b0;
				end else if ((match[ch] && !forceHit[ch]) || capture[ch]) begin
					chFlag_q[ch] <= 1'b1;
				end else if (chClr[ch]) begin
					chFlag_q[ch] <= 1'b0;
				end
			end

			// Overflow toggle first, then force or match runs the action.
			always_ff @(posedge ref_clk or negedge rstSync_n) begin
				if (!rstSync_n) begin
					pinOut_q[ch] <= 1'b0;
				end else if (wrap && toggle_q[ch] && mode_q[ch]) begin
					pinOut_q[ch] <= !pinOut_q[ch];
				end else if (forceHit[ch] || match[ch]) begin
					case (act)
						ACT_TOGGLE: pinOut_q[ch] <= !pinOut_q[ch];
						ACT_LOW: pinOut_q[ch] <= 1'b0;
						ACT_HIGH: pinOut_q[ch] <= 1'b1;
						default: ;
					endcase
				end
			end
		end
	endgenerate

	assign chPinOut = pinOut_q;

	// Overflow flag; any counter access clears it under fast clearing.
	assign cntAccess = ctrl_q.fastClr
		&& ((rdFire && (rdIdx == IDX_CNT_HI || rdIdx == IDX_CNT_LO))
		|| (wrFire && (wrIdx == IDX_CNT_HI || wrIdx == IDX_CNT_LO)));
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ovFlag_q <= 1'b0;
		end else if (wrap) begin
			ovFlag_q <= 1'b1;
		end else if (cntAccess) begin
			ovFlag_q <= 1'b0;
		end else if (wrLo && wrIdx == IDX_OVFLAG && ctrl_q.en
			&& wb[BIT_OVFLAG]) begin
			ovFlag_q <= 1'b0;
		end
	end

	// Read multiplexer; absent channel bits are zero-extended.
	always_comb begin
		rdData = '0;
		case (rdIdx)
			IDX_MODE: rdData = 32'(mode_q);
			IDX_FORCE: rdData = '0;
			IDX_CNT_HI: rdData = 32'(cnt_q[15:8]);
			IDX_CNT_LO: rdData = 32'(cnt_q[7:0]);
			IDX_CTRL1: rdData = 32'({ctrl_q, 3'h0});
			IDX_TOGGLE: rdData = 32'(toggle_q);
			IDX_ACTION: rdData = 32'(action_q);
			IDX_EDGE: rdData = 32'(edge_q);
			IDX_CTRL2: rdData = 32'(legacy_q);
			IDX_CHFLAG: rdData = 32'(chFlag_q);
			IDX_OVFLAG: rdData = 32'({ovFlag_q, 7'h00});
			IDX_PRECISE: rdData = 32'(precise_q);
			default: begin
				if (isChVal(rdIdx)) begin
					rdData = 32'(chVal_q[chOf(rdIdx)]);
				end
			end
		endcase
	end

	// Known register indices; anything else answers with an error.
	function automatic logic isMapped(input logic [5:0] idx);
		return idx == IDX_MODE || idx == IDX_FORCE || idx == IDX_CNT_HI
			|| idx == IDX_CNT_LO || idx == IDX_CTRL1 || idx == IDX_TOGGLE
			|| idx == IDX_ACTION || idx == IDX_EDGE || idx == IDX_CTRL2
			|| idx == IDX_CHFLAG || idx == IDX_OVFLAG
			|| idx == IDX_PRECISE || isChVal(idx);
	endfunction : isMapped

	// Write response stands until the master takes it.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			bValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
		end else if (wrFire) begin
			bValid_q <= 1'b1;
			bResp_q <= isMapped(wrIdx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_q <= 1'b0;
		end
	end

	// Read data stands until the master takes it.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rValid_q <= 1'b0;
			rResp_q <= RESP_OKAY;
			rData_q <= '0;
		end else if (rdFire) begin
			rValid_q <= 1'b1;
			rResp_q <= isMapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
			rData_q <= rdData;
		end else if (s_axi_rready) begin
			rValid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rresp = rResp_q;
	assign s_axi_rdata = rData_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstSync_n);

	// Checks on the timer behaviour.
	force_reads_zero_a: assert property (
		rdFire && rdIdx == IDX_FORCE |=> s_axi_rvalid && s_axi_rdata == '0)
		else $error("force register read not zero");
	force_no_flag_a: assert property (
		forceHit[0] && !chFlag_q[0] |=> !chFlag_q[0])
		else $error("forced compare set the channel flag");
	counter_step_a: assert property (
		cntTick && !cntWrite |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
		else $error("counter did not step by one");
	counter_stopped_a: assert property (
		!ctrl_q.en && !cntWrite |=> $stable(cnt_q))
		else $error("counter moved while disabled");
	counter_locked_a: assert property (
		wrFire && !testMode && !cntTick |=> $stable(cnt_q))
		else $error("counter written outside test mode");
	freeze_halt_a: assert property (
		freezeMode && ctrl_q.stopFreeze |-> !cntTick)
		else $error("counter ran in freeze");
	wait_stop_a: assert property (
		waitMode && ctrl_q.stopWait |-> !paTick && !preTick)
		else $error("timer ran in wait");
	wrap_flag_a: assert property (
		wrap |=> ovFlag_q && cnt_q == '0)
		else $error("wrap did not set overflow flag");
	prec_once_a: assert property (
		precDone_q && wrLo && wrIdx == IDX_CTRL1 |=> $stable(ctrl_q.precSel))
		else $error("precision bit changed twice");
	ovf_toggle_a: assert property (
		wrap && toggle_q[0] && mode_q[0] |=> pinOut_q[0] != $past(pinOut_q[0]))
		else $error("overflow toggle missed");

endmodule : cct_core

// ===== cct_pkg.sv
/*
 * Shared constants and types of the capture/compare timer core.
 * Assumes an AXI4-Lite register bus with 32-bit data, one register a word.
 */
package cct_pkg;

	// Counter, prescaler and bus widths.
	localparam int CNT_W = 16;
	localparam int PRE_W = 8;
	localparam int LEG_W = 3;
	localparam int ADDR_W = 8;
	localparam int PA_W = 6;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_MODE = 6'h00;
	localparam logic [5:0] IDX_FORCE = 6'h01;
	localparam logic [5:0] IDX_CNT_HI = 6'h04;
	localparam logic [5:0] IDX_CNT_LO = 6'h05;
	localparam logic [5:0] IDX_CTRL1 = 6'h06;
	localparam logic [5:0] IDX_TOGGLE = 6'h07;
	localparam logic [5:0] IDX_ACTION = 6'h09;
	localparam logic [5:0] IDX_EDGE = 6'h0B;
	localparam logic [5:0] IDX_CTRL2 = 6'h0D;
	localparam logic [5:0] IDX_CHFLAG = 6'h0E;
	localparam logic [5:0] IDX_OVFLAG = 6'h0F;
	localparam logic [5:0] IDX_CHVAL = 6'h10;
	localparam logic [5:0] IDX_PRECISE = 6'h2E;

	// Bit positions in the control and overflow flag registers.
	localparam int BIT_EN = 7;
	localparam int BIT_STOPWAIT = 6;
	localparam int BIT_STOPFRZ = 5;
	localparam int BIT_FASTCLR = 4;
	localparam int BIT_PRECSEL = 3;
	localparam int BIT_OVFLAG = 7;

	// Counter limit and output action codes.
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW = 2'h2;
	localparam logic [1:0] ACT_HIGH = 2'h3;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Global control bits of the timer.
	typedef struct packed {
		logic en;
		logic stopWait;
		logic stopFreeze;
		logic fastClr;
		logic precSel;
	} cct_ctrl_type;

endpackage : cct_pkg

// ===== cct_prescaler.sv
/*
 * Timer prescaler: divides the bus clock for the main counter and makes
 * the divide-by-64 tick for the pulse accumulator.
 * Assumes run comes from logic on the same clock.
 */
`timescale 1ns/1ns
module cct_prescaler
	import cct_pkg::*;
#(
	parameter int PRE_WIDTH = PRE_W
) (
	input wire logic ref_clk,
	input wire logic rstSync_n,
	input wire logic run,
	input wire logic precSel,
	input wire logic [LEG_W-1:0] legacyCode,
	input wire logic [PRE_WIDTH-1:0] preciseDiv,
	output logic tick,
	output logic paTick
);

	logic [PRE_WIDTH-1:0] stage_q;
	logic [PRE_WIDTH-1:0] active_q;
	logic [PRE_WIDTH-1:0] request;
	logic [PA_W-1:0] pa_q;

	// Divide factor: power of two in legacy mode, value plus one otherwise.
	always_comb begin
		if (precSel) begin
			request = preciseDiv;
		end else begin
			request = PRE_WIDTH'((1 << legacyCode) - 1);
		end
	end

	assign tick = run && (stage_q == active_q);

	// A new factor is loaded only as the stages return to zero.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			stage_q <= '0;
			active_q <= '0;
		end else if (tick) begin
			stage_q <= '0;
			active_q <= request;
		end else if (run) begin
			stage_q <= PRE_WIDTH'(stage_q + 1'b1);
		end
	end

	// Pulse accumulator clock exists only while the timer is active.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pa_q <= '0;
		end else if (run) begin
			pa_q <= PA_W'(pa_q + 1'b1);
		end
	end

	assign paTick = run && (&pa_q);

endmodule : cct_prescaler

// ===== cct_pin_model.sv
/*
 * Model of the far side of the channel pins: an outside source that drives
 * each pin while the timer core leaves it undriven.
 * Assumes the core's pin outputs and enables are settled on its clock.
 */
`timescale 1ns/1ns
module cct_pin_model #(
	parameter int N = 3
) (
	input wire logic [N-1:0] pinOut,
	input wire logic [N-1:0] pinOe,
	input wire logic [N-1:0] extDrive,
	output logic [N-1:0] pinLevel
);
	// A pin shows the core's level while it drives, else the outside level.
	assign pinLevel = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule : cct_pin_model

// ===== cct_core_tb.sv
/*
 * Self-checking bench for the timer core, driven over AXI4-Lite.
 * Assumes the core answers each request one cycle after taking it.
 */
`timescale 1ns/1ns
module cct_core_tb;
	import cct_pkg::*;
	localparam int NCH = 3;
	logic ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, waitMode, freezeMode, testMode;
	logic paTick, p;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv, a;
	logic [7:0] d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, lastResp;
	logic [NCH-1:0] pinIn, pinOut, pinOe, extDrive;
	logic [1:0] codes [5] = '{ACT_HIGH, ACT_LOW, ACT_TOGGLE, ACT_TOGGLE,
		ACT_NONE};
	logic pinExp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int err_total, n_checks, cyc, paCnt, pa0;

	cct_core #(.NUM_CH(NCH)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .waitMode(waitMode), .freezeMode(freezeMode),
		.testMode(testMode), .chPinIn(pinIn), .chPinOut(pinOut),
		.chPinOe(pinOe), .paTick(paTick));

	cct_pin_model #(.N(NCH)) pins (.pinOut(pinOut), .pinOe(pinOe),
		.extDrive(extDrive), .pinLevel(pinIn));

	// Free-running bus clock of 50 ns.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Counts accumulator ticks and cuts a hung run short.
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (paTick === 1'b1) begin
			paCnt = paCnt + 1;
		end
		if (cyc == 6000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge ref_clk); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		lastResp = bresp;
		bready <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [5:0] idx);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		rdv = rdata;
		lastResp = rresp;
		rready <= 1'b0;
		@(posedge ref_clk);
	endtask : rd

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cycles

	// Loads the counter through the test-mode path.
	task automatic loadCount();
		testMode <= 1'b1;
		wr(IDX_CNT_HI, 16'h00FF);
		wr(IDX_CNT_LO, 16'h00F0);
		testMode <= 1'b0;
	endtask : loadCount

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence of register-level tests.
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{waitMode, freezeMode, testMode, awaddr, araddr} = 19'h0_0000;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		extDrive = 3'h0;
		err_total = 0;
		n_checks = 0;
		cyc = 0;
		paCnt = 0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		cycles(3);
		rd(IDX_TOGGLE);
		check("toggle reset", rdv, 32'h0000_0000);
		wr(IDX_MODE, 16'h00FF);
		rd(IDX_MODE);
		check("mode bits", rdv, 32'h0000_0007);
		wr(IDX_FORCE, 16'h00FF);
		rd(IDX_FORCE);
		check("force read", rdv, 32'h0000_0000);
		wr(IDX_CTRL1, 16'h0000);
		wr(IDX_CTRL1, 16'h0008);
		rd(IDX_CTRL1);
		check("ctrl1 once", rdv, 32'h0000_0000);
		// Every action code applied through a forced compare on channel 0.
		for (int i = 0; i < 5; i++) begin
			wr(IDX_ACTION, {14'h0000, codes[i]});
			wr(IDX_FORCE, 16'h0001);
			cycles(2);
			check("pin0", {31'h0, pinOut[0]}, {31'h0, pinExp[i]});
		end
		check("oe0 idle", {31'h0, pinOe[0]}, 32'h0000_0000);
		rd(IDX_CHFLAG);
		check("force flag", rdv, 32'h0000_0000);
		wr(IDX_MODE, 16'h0003);
		wr(IDX_ACTION, 16'h0030);
		wr(IDX_FORCE, 16'h0004);
		cycles(2);
		check("oe2 capture", {31'h0, pinOe[2]}, 32'h0000_0000);
		wr(IDX_CNT_HI, 16'h00FF);
		rd(IDX_CNT_HI);
		check("cnt normal wr", rdv, 32'h0000_0000);
		loadCount();
		rd(IDX_CNT_HI);
		check("cnt hi", rdv, 32'h0000_00FF);
		rd(IDX_CNT_LO);
		check("cnt lo", rdv, 32'h0000_00F0);
		wr(IDX_TOGGLE, 16'h0003);
		wr(IDX_ACTION, 16'h0000);
		wr(IDX_EDGE, 16'h0010);
		p = pinOut[1];
		wr(IDX_CTRL1, 16'h0080);
		cycles(40);
		rd(IDX_OVFLAG);
		check("ovf set", rdv, 32'h0000_0080);
		check("pin1 ovf", {31'h0, pinOut[1]}, {31'h0, ~p});
		extDrive <= 3'h4;
		cycles(6);
		rd(IDX_CHFLAG);
		check("capture flag", rdv & 32'h4, 32'h0000_0004);
		rd(IDX_CNT_LO);
		a = rdv;
		rd(IDX_CNT_LO);
		check("cnt runs", {31'h0, a !== rdv}, 32'h0000_0001);
		wr(IDX_CTRL1, 16'h0000);
		wr(IDX_OVFLAG, 16'h0080);
		rd(IDX_OVFLAG);
		check("ovf no clr", rdv, 32'h0000_0080);
		wr(IDX_CTRL1, 16'h0080);
		wr(IDX_OVFLAG, 16'h0080);
		rd(IDX_OVFLAG);
		check("ovf clr", rdv, 32'h0000_0000);
		wr(IDX_CTRL1, 16'h0000);
		rd(IDX_CNT_LO);
		a = rdv;
		pa0 = paCnt;
		cycles(140);
		check("no pa tick", paCnt - pa0, 32'h0000_0000);
		rd(IDX_CNT_LO);
		check("cnt stopped", rdv, a);
		loadCount();
		p = pinOut[1];
		wr(IDX_CTRL1, 16'h0090);
		cycles(40);
		check("pin1 ovf2", {31'h0, pinOut[1]}, {31'h0, ~p});
		rd(IDX_CNT_LO);
		rd(IDX_OVFLAG);
		check("fast ovf clr", rdv, 32'h0000_0000);
		rd(IDX_CHVAL + 6'h04);
		rd(IDX_CHFLAG);
		check("fast ch clr", rdv & 32'h4, 32'h0000_0000);
		// Freeze halts the counter only; wait halts the accumulator too.
		wr(IDX_CTRL1, 16'h00A0);
		freezeMode <= 1'b1;
		rd(IDX_CNT_LO);
		a = rdv;
		pa0 = paCnt;
		cycles(140);
		rd(IDX_CNT_LO);
		check("freeze cnt", rdv, a);
		check("freeze pa", {31'h0, paCnt > pa0}, 32'h0000_0001);
		freezeMode <= 1'b0;
		wr(IDX_CTRL1, 16'h00C0);
		waitMode <= 1'b1;
		rd(IDX_CNT_LO);
		a = rdv;
		pa0 = paCnt;
		cycles(140);
		rd(IDX_CNT_LO);
		check("wait cnt", rdv, a);
		check("wait pa", paCnt - pa0, 32'h0000_0000);
		waitMode <= 1'b0;
		// Legacy code 3 divides by eight: 83 cycles give 10 or 11 counts.
		wr(IDX_CTRL2, 16'h0003);
		rd(IDX_CNT_LO);
		a = rdv;
		cycles(80);
		rd(IDX_CNT_LO);
		d = rdv[7:0] - a[7:0];
		p = (d == 8'h0A) || (d == 8'h0B);
		check("legacy div", {31'h0, p}, 32'h0000_0001);
		rd(6'h30);
		check("bad rd", {30'h0, lastResp}, {30'h0, RESP_SLVERR});
		wr(6'h30, 16'h0001);
		check("bad wr", {30'h0, lastResp}, {30'h0, RESP_SLVERR});
		// A second reset opens the one write of the precision bit.
		rst_n <= 1'b0;
		cycles(3);
		rst_n <= 1'b1;
		cycles(3);
		wr(IDX_MODE, 16'h0001);
		wr(IDX_ACTION, 16'h0003);
		wr(IDX_CHVAL, 16'h0040);
		wr(IDX_CTRL1, 16'h0088);
		wr(IDX_PRECISE, 16'h0003);
		// Precise value 3 divides by four: 83 cycles give 20 or 21 counts.
		rd(IDX_CNT_LO);
		a = rdv;
		cycles(80);
		rd(IDX_CNT_LO);
		d = rdv[7:0] - a[7:0];
		p = (d == 8'h14) || (d == 8'h15);
		check("precise div", {31'h0, p}, 32'h0000_0001);
		cycles(200);
		rd(IDX_CHFLAG);
		check("match flag", rdv, 32'h0000_0001);
		check("match pin", {31'h0, pinOut[0]}, 32'h0000_0001);
		wr(IDX_CTRL1, 16'h0090);
		rd(IDX_CTRL1);
		check("prec kept", rdv, 32'h0000_0098);
		wr(IDX_CHVAL, 16'h0000);
		rd(IDX_CHFLAG);
		check("fast oc clr", rdv, 32'h0000_0000);
		report_and_stop();
	end
endmodule : cct_core_tb
